/* design/ebso_pkg.sv */
// shared constants, types and register map of the external bus controller
package ebso_pkg;

    // bus widths of the attached device
    localparam int ADDR_W = 24;
    localparam int DATA_W = 32;
    localparam int BE_W   = DATA_W / 8;
    localparam int BYTE_W = 8;

    // optional pin signals; an option that is off leaves its pin idle
    localparam bit OPT_READ    = 1'b1;
    localparam bit OPT_WRITE   = 1'b1;
    localparam bit OPT_BE      = 1'b1;
    localparam bit OPT_CS      = 1'b1;
    localparam bit OPT_LOCK    = 1'b1;
    localparam bit OPT_WAIT    = 1'b1;
    localparam bit OPT_WBE     = 1'b0;
    localparam bit OPT_RSTREQ  = 1'b1;
    localparam bit OPT_IRQ     = 1'b1;
    localparam bit OPT_RSTOUT  = 1'b1;
    localparam bit OPT_BEGIN   = 1'b1;

    // register byte addresses on the apb side
    localparam logic [7:0] REG_ADDR   = 8'h00;
    localparam logic [7:0] REG_WDATA  = 8'h04;
    localparam logic [7:0] REG_BYTEEN = 8'h08;
    localparam logic [7:0] REG_CMD    = 8'h0C;
    localparam logic [7:0] REG_RDATA  = 8'h10;
    localparam logic [7:0] REG_STATUS = 8'h14;
    localparam logic [7:0] REG_CTRL   = 8'h18;

    // field positions
    localparam int CMD_RD_BIT     = 0;
    localparam int CMD_WR_BIT     = 1;
    localparam int CMD_LOCK_BIT   = 2;
    localparam int ST_BUSY_BIT    = 0;
    localparam int ST_LOCKED_BIT  = 1;
    localparam int ST_IRQ_BIT     = 2;
    localparam int ST_RSTREQ_BIT  = 3;
    localparam int CTRL_RST_BIT   = 0;

    // reset values
    localparam logic [ADDR_W-1:0] ADDR_RST  = 24'h00_0000;
    localparam logic [DATA_W-1:0] DATA_RST  = 32'h0000_0000;
    localparam logic [BE_W-1:0]   BE_RST    = 4'hF;

    // transfer sequencer states
    typedef enum logic [1:0] {
        S_IDLE,
        S_REQ,
        S_ACCESS
    } ebso_state_t;

    // everything driven toward the pin sharer, registered as one group
    typedef struct packed {
        logic              request;
        logic [ADDR_W-1:0] address;
        logic              rd;
        logic              wr;
        logic              cs;
        logic [BE_W-1:0]   be;
        logic [BE_W-1:0]   wbe;
        logic              lock;
        logic [DATA_W-1:0] wdata;
        logic              wdata_oe;
        logic              begin_xfer;
        logic              dev_reset;
    } ebso_pin_t;

    localparam ebso_pin_t PIN_RST = '0;

endpackage : ebso_pkg

/* design/ebso_pin_stage.sv */
// output register stage that applies the optional pin gating
`timescale 1ns/1ns
`default_nettype none

module ebso_pin_stage (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire ebso_pkg::ebso_pin_t raw_d,
    output var  ebso_pkg::ebso_pin_t pin_q
);

    ebso_pkg::ebso_pin_t pin_d;

    // gate the raw strobes by the configured options
    always_comb begin
        pin_d     = raw_d;
        pin_d.rd  = raw_d.rd & ebso_pkg::OPT_READ;
        pin_d.wr  = raw_d.wr & ebso_pkg::OPT_WRITE;
        pin_d.cs  = ebso_pkg::OPT_CS & (pin_d.rd | pin_d.wr);
        pin_d.wbe = ebso_pkg::OPT_WBE ? ({ebso_pkg::BE_W{pin_d.wr}} & raw_d.be)
                                      : '0;
        if (ebso_pkg::OPT_WBE) begin
            pin_d.wr = 1'b0;
            pin_d.be = '0;
        end else if (!ebso_pkg::OPT_BE) begin
            pin_d.be = '0;
        end
        pin_d.lock       = raw_d.lock & ebso_pkg::OPT_LOCK;
        pin_d.begin_xfer = raw_d.begin_xfer & ebso_pkg::OPT_BEGIN;
        pin_d.dev_reset  = raw_d.dev_reset & ebso_pkg::OPT_RSTOUT;
        pin_d.wdata_oe   = raw_d.wdata_oe & ebso_pkg::OPT_WRITE;
    end

    // register the pin group
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_q <= ebso_pkg::PIN_RST;
        end else begin
            pin_q <= pin_d;
        end
    end

endmodule : ebso_pin_stage

`default_nettype wire

/* design/ebso_ctrl.sv */
// apb-controlled external bus controller with optional pin signals
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - each byte-lane enable bit n governs data byte n of the external word.
// - on a write only the enabled bytes are marked, and the device ignores the rest.
// - on a read the byte-lane enables show which lanes of returned data are read.
// - chip select is only ever asserted together with a read or write strobe.
// - a locked sequence keeps the request, and so the grant, across its transactions.
// - lock rises with the first access of a locked sequence and is low on the last.
// - the address pins always carry a byte address.
// - each combined write byte enable bit is write strobe AND its byte-lane enable.
// - with combined write byte enables, separate write and byte-enable pins stay idle.
// - a device interrupt is passed on to the register side.
// - the device reset output is driven on software request.
// - the request and grant handshake is always present on the pin side.
// - read data input goes with the read strobe and write data output with write.
// - begin-transfer is high in the first cycle of every access, wait or not.
module ebso_ctrl (
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [7:0]                    paddr,
    input  wire logic [31:0]                   pwdata,
    output var  logic [31:0]                   prdata,
    output var  logic                          pready,
    output var  logic                          pslverr,
    output var  logic                          tc_request,
    input  wire logic                          tc_grant,
    output var  logic [ebso_pkg::ADDR_W-1:0]   tc_address,
    output var  logic                          tc_read,
    output var  logic                          tc_write,
    output var  logic                          tc_chipselect,
    output var  logic [ebso_pkg::BE_W-1:0]     tc_byteenable,
    output var  logic [ebso_pkg::BE_W-1:0]     tc_writebyteenable,
    output var  logic                          tc_lock,
    output var  logic                          tc_begintransfer,
    input  wire logic [ebso_pkg::DATA_W-1:0]   tc_data_in,
    output var  logic [ebso_pkg::DATA_W-1:0]   tc_data_out,
    output var  logic                          tc_data_oe,
    input  wire logic                          tc_waitrequest,
    input  wire logic                          tc_resetrequest,
    input  wire logic                          tc_irq,
    output var  logic                          tc_reset_out,
    output var  logic                          sys_reset_req,
    output var  logic                          irq
);

    // expand byte-lane enables to a bit mask over the data word
    function automatic logic [ebso_pkg::DATA_W-1:0] lane_mask(
        input logic [ebso_pkg::BE_W-1:0] be
    );
        logic [ebso_pkg::DATA_W-1:0] m;
        m = '0;
        for (int i = 0; i < ebso_pkg::BE_W; i++) begin
            m[i*ebso_pkg::BYTE_W +: ebso_pkg::BYTE_W] = {ebso_pkg::BYTE_W{be[i]}};
        end
        return m;
    endfunction : lane_mask

    // registered state
    ebso_pkg::ebso_state_t       state_q, state_d;
    logic [ebso_pkg::ADDR_W-1:0] addr_q, addr_d;
    logic [ebso_pkg::DATA_W-1:0] wdata_q, wdata_d;
    logic [ebso_pkg::BE_W-1:0]   be_q, be_d;
    logic                        cmd_rd_q, cmd_rd_d;
    logic                        cmd_lock_q, cmd_lock_d;
    logic                        locked_q, locked_d;
    logic [ebso_pkg::DATA_W-1:0] rdata_q, rdata_d;
    logic                        ctrl_rst_q, ctrl_rst_d;
    logic                        rstreq_q, rstreq_d;
    logic                        irq_q, irq_d;
    logic [31:0]                 prdata_q, prdata_d;
    logic                        pready_q, pready_d;
    logic                        pslverr_q, pslverr_d;
    ebso_pkg::ebso_pin_t         raw_d;
    ebso_pkg::ebso_pin_t         pin_q;

    logic                        wr_take;
    logic                        setup;
    logic                        done;

    // bus phase decode
    assign setup   = psel & ~penable;
    assign wr_take = psel & penable & pready_q & pwrite;
    assign done    = (state_q == ebso_pkg::S_ACCESS) &
                     ~(tc_waitrequest & ebso_pkg::OPT_WAIT);

    // next values of registers, sequencer and apb answer
    always_comb begin
        state_d    = state_q;
        addr_d     = addr_q;
        wdata_d    = wdata_q;
        be_d       = be_q;
        cmd_rd_d   = cmd_rd_q;
        cmd_lock_d = cmd_lock_q;
        locked_d   = locked_q;
        rdata_d    = rdata_q;
        ctrl_rst_d = ctrl_rst_q;
        rstreq_d   = tc_resetrequest & ebso_pkg::OPT_RSTREQ;
        irq_d      = tc_irq & ebso_pkg::OPT_IRQ;
        pready_d   = setup;
        pslverr_d  = 1'b0;
        prdata_d   = '0;
        // software writes; transfer fields are frozen while busy
        if (wr_take) begin
            case (paddr)
                ebso_pkg::REG_ADDR: begin
                    if (state_q == ebso_pkg::S_IDLE) begin
                        addr_d = pwdata[ebso_pkg::ADDR_W-1:0];
                    end
                end
                ebso_pkg::REG_WDATA: begin
                    if (state_q == ebso_pkg::S_IDLE) begin
                        wdata_d = pwdata;
                    end
                end
                ebso_pkg::REG_BYTEEN: begin
                    if (state_q == ebso_pkg::S_IDLE) begin
                        be_d = pwdata[ebso_pkg::BE_W-1:0];
                    end
                end
                ebso_pkg::REG_CMD: begin
                    if (state_q == ebso_pkg::S_IDLE &&
                        (pwdata[ebso_pkg::CMD_RD_BIT] || pwdata[ebso_pkg::CMD_WR_BIT])) begin
                        state_d    = ebso_pkg::S_REQ;
                        cmd_rd_d   = pwdata[ebso_pkg::CMD_RD_BIT];
                        cmd_lock_d = pwdata[ebso_pkg::CMD_LOCK_BIT] & ebso_pkg::OPT_LOCK;
                    end
                end
                ebso_pkg::REG_CTRL: begin
                    ctrl_rst_d = pwdata[ebso_pkg::CTRL_RST_BIT];
                end
                default: begin
                end
            endcase
        end
        // transfer sequencer
        case (state_q)
            ebso_pkg::S_IDLE: begin
            end
            ebso_pkg::S_REQ: begin
                if (tc_grant) begin
                    state_d = ebso_pkg::S_ACCESS;
                end
            end
            ebso_pkg::S_ACCESS: begin
                if (done) begin
                    state_d  = ebso_pkg::S_IDLE;
                    locked_d = cmd_lock_q;
                    if (cmd_rd_q) begin
                        rdata_d = tc_data_in & lane_mask(be_q);
                    end
                end
            end
            default: begin
                state_d = ebso_pkg::S_IDLE;
            end
        endcase
        // apb read data and error, prepared in the setup cycle
        if (setup) begin
            case (paddr)
                ebso_pkg::REG_ADDR:   prdata_d[ebso_pkg::ADDR_W-1:0] = addr_q;
                ebso_pkg::REG_WDATA:  prdata_d = wdata_q;
                ebso_pkg::REG_BYTEEN: prdata_d[ebso_pkg::BE_W-1:0] = be_q;
                ebso_pkg::REG_CMD: begin
                    prdata_d[ebso_pkg::CMD_RD_BIT]   = cmd_rd_q;
                    prdata_d[ebso_pkg::CMD_WR_BIT]   = ~cmd_rd_q;
                    prdata_d[ebso_pkg::CMD_LOCK_BIT] = cmd_lock_q;
                end
                ebso_pkg::REG_RDATA:  prdata_d = rdata_q;
                ebso_pkg::REG_STATUS: begin
                    prdata_d[ebso_pkg::ST_BUSY_BIT]   = (state_q != ebso_pkg::S_IDLE);
                    prdata_d[ebso_pkg::ST_LOCKED_BIT] = locked_q;
                    prdata_d[ebso_pkg::ST_IRQ_BIT]    = irq_q;
                    prdata_d[ebso_pkg::ST_RSTREQ_BIT] = rstreq_q;
                end
                ebso_pkg::REG_CTRL:   prdata_d[ebso_pkg::CTRL_RST_BIT] = ctrl_rst_q;
                default:              pslverr_d = 1'b1;
            endcase
        end
    end

    // register all of the above
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q    <= ebso_pkg::S_IDLE;
            addr_q     <= ebso_pkg::ADDR_RST;
            wdata_q    <= ebso_pkg::DATA_RST;
            be_q       <= ebso_pkg::BE_RST;
            cmd_rd_q   <= 1'b0;
            cmd_lock_q <= 1'b0;
            locked_q   <= 1'b0;
            rdata_q    <= ebso_pkg::DATA_RST;
            ctrl_rst_q <= 1'b0;
            rstreq_q   <= 1'b0;
            irq_q      <= 1'b0;
            prdata_q   <= '0;
            pready_q   <= 1'b0;
            pslverr_q  <= 1'b0;
        end else begin
            state_q    <= state_d;
            addr_q     <= addr_d;
            wdata_q    <= wdata_d;
            be_q       <= be_d;
            cmd_rd_q   <= cmd_rd_d;
            cmd_lock_q <= cmd_lock_d;
            locked_q   <= locked_d;
            rdata_q    <= rdata_d;
            ctrl_rst_q <= ctrl_rst_d;
            rstreq_q   <= rstreq_d;
            irq_q      <= irq_d;
            prdata_q   <= prdata_d;
            pready_q   <= pready_d;
            pslverr_q  <= pslverr_d;
        end
    end

    // raw pin values, aligned with the sequencer's next state
    always_comb begin
        raw_d            = ebso_pkg::PIN_RST;
        raw_d.request    = (state_d != ebso_pkg::S_IDLE) | locked_d;
        raw_d.address    = addr_d;
        raw_d.rd         = (state_d == ebso_pkg::S_ACCESS) & cmd_rd_d;
        raw_d.wr         = (state_d == ebso_pkg::S_ACCESS) & ~cmd_rd_d;
        raw_d.be         = be_d;
        raw_d.lock       = (state_d == ebso_pkg::S_ACCESS) & cmd_lock_d;
        raw_d.wdata      = wdata_d & lane_mask(be_d);
        raw_d.wdata_oe   = raw_d.wr;
        raw_d.begin_xfer = (state_d == ebso_pkg::S_ACCESS) &
                           (state_q != ebso_pkg::S_ACCESS);
        raw_d.dev_reset  = ctrl_rst_d;
    end

    ebso_pin_stage u_pin_stage (
        .pclk    (pclk),
        .presetn (presetn),
        .raw_d   (raw_d),
        .pin_q   (pin_q)
    );

    // top outputs, all taken from flip-flops
    assign prdata             = prdata_q;
    assign pready             = pready_q;
    assign pslverr            = pslverr_q;
    assign tc_request         = pin_q.request;
    assign tc_address         = pin_q.address;
    assign tc_read            = pin_q.rd;
    assign tc_write           = pin_q.wr;
    assign tc_chipselect      = pin_q.cs;
    assign tc_byteenable      = pin_q.be;
    assign tc_writebyteenable = pin_q.wbe;
    assign tc_lock            = pin_q.lock;
    assign tc_begintransfer   = pin_q.begin_xfer;
    assign tc_data_out        = pin_q.wdata;
    assign tc_data_oe         = pin_q.wdata_oe;
    assign tc_reset_out       = pin_q.dev_reset;
    assign sys_reset_req      = rstreq_q;
    assign irq                = irq_q;

    // checks on the pin side behaviour
    AST_CS_WITH_STROBE: assert property (@(posedge pclk) disable iff (!presetn)
        tc_chipselect |-> (tc_read || tc_write || tc_writebyteenable != '0))
        else $error("chip select without a strobe");
    AST_WBE_AND: assert property (@(posedge pclk) disable iff (!presetn)
        tc_writebyteenable == ({ebso_pkg::BE_W{ebso_pkg::OPT_WBE &&
            state_q == ebso_pkg::S_ACCESS && !cmd_rd_q}} & be_q))
        else $error("write byte enables differ from lane enables");
    AST_BEGIN_FIRST: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(state_q == ebso_pkg::S_ACCESS) |-> tc_begintransfer ##1 !tc_begintransfer)
        else $error("begin-transfer not a single first-cycle pulse");
    AST_HOLD_ON_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
        (tc_read && tc_waitrequest) |=> tc_read && $stable(tc_address))
        else $error("read dropped while device waits");
    AST_LOCK_FIRST: assert property (@(posedge pclk) disable iff (!presetn)
        ($rose(tc_read || tc_write) && cmd_lock_q) |-> tc_lock)
        else $error("lock missing on first locked access");
    AST_LOCK_LAST: assert property (@(posedge pclk) disable iff (!presetn)
        ((tc_read || tc_write) && !cmd_lock_q) |-> !tc_lock)
        else $error("lock high on final access");
    AST_REQ_HELD: assert property (@(posedge pclk) disable iff (!presetn)
        (locked_q || tc_read || tc_write) |-> tc_request)
        else $error("request dropped during access or lock");
    AST_ADDR_BYTE: assert property (@(posedge pclk) disable iff (!presetn)
        (tc_read || tc_write) |-> (tc_address == addr_q && tc_byteenable == be_q))
        else $error("address or lanes differ from programmed values");
    AST_RDATA_LANES: assert property (@(posedge pclk) disable iff (!presetn)
        (tc_read && done) |=> rdata_q == ($past(tc_data_in) & lane_mask(be_q)))
        else $error("read data lanes not masked");
    AST_RST_FWD: assert property (@(posedge pclk) disable iff (!presetn)
        tc_resetrequest |=> sys_reset_req)
        else $error("reset request not forwarded");
    AST_IRQ_FWD: assert property (@(posedge pclk) disable iff (!presetn)
        tc_irq |=> irq)
        else $error("interrupt not forwarded");
    AST_RST_OUT: assert property (@(posedge pclk) disable iff (!presetn)
        tc_reset_out == ctrl_rst_q)
        else $error("device reset not driven");

endmodule : ebso_ctrl

`default_nettype wire

/* tb/ebso_dev_model.sv */
// behavioural external memory with grant and wait insertion
`timescale 1ns/1ns
`default_nettype none

module ebso_dev_model (
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        tc_request,
    input  wire logic [ebso_pkg::ADDR_W-1:0] tc_address,
    input  wire logic                        tc_read,
    input  wire logic                        tc_write,
    input  wire logic [ebso_pkg::BE_W-1:0]   tc_byteenable,
    input  wire logic [ebso_pkg::DATA_W-1:0] tc_data_out,
    input  wire logic [3:0]                  grant_delay,
    input  wire logic [3:0]                  wait_n,
    output var  logic                        tc_grant,
    output var  logic [ebso_pkg::DATA_W-1:0] tc_data_in,
    output var  logic                        tc_waitrequest
);
    logic [31:0] mem [64];
    logic [31:0] last;
    logic [3:0]  gcnt;
    logic [3:0]  wcnt;

    // stall each strobe for wait_n cycles
    assign tc_waitrequest = (tc_read | tc_write) && (wcnt < wait_n);
    // released data lines show the inverse of the last word
    assign tc_data_in = tc_read ? mem[tc_address[7:2]] : ~last;

    // grant after a delay, stall count, byte-wise storage; reset fills a known pattern
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 64; i++) begin
                mem[i] <= 32'hA5A5_A5A5;
            end
            gcnt     <= '0;
            tc_grant <= 1'b0;
            wcnt     <= '0;
            last     <= '0;
        end else begin
            gcnt     <= tc_request ? ((gcnt < grant_delay) ? gcnt + 4'd1 : gcnt) : 4'd0;
            tc_grant <= tc_request && (gcnt >= grant_delay);
            wcnt     <= (tc_read | tc_write) ? ((wcnt < wait_n) ? wcnt + 4'd1 : wcnt) : 4'd0;
            if (tc_read) begin
                last <= mem[tc_address[7:2]];
            end
            if (tc_write && !tc_waitrequest) begin
                for (int b = 0; b < 4; b++) begin
                    if (tc_byteenable[b]) begin
                        mem[tc_address[7:2]][8*b+:8] <= tc_data_out[8*b+:8];
                    end
                end
            end
        end
    end
endmodule : ebso_dev_model
`default_nettype wire

/* tb/tb_ebso_ctrl.sv */
// self-checking bench for the external bus controller
`timescale 1ns/1ns
`default_nettype none

module tb_ebso_ctrl;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, tc_data_in, tc_data_out, seen_data;
    logic tc_request, tc_grant, tc_read, tc_write, tc_chipselect, tc_lock, tc_begintransfer;
    logic tc_data_oe, tc_waitrequest, tc_resetrequest, tc_irq, tc_reset_out, sys_reset_req, irq;
    logic [23:0] tc_address, seen_addr, addr_p;
    logic [3:0] tc_byteenable, tc_writebyteenable, seen_be, grant_delay, wait_n;
    logic seen_lock, st_p, wt_p;
    int errors, n_checks, n_begin;

    ebso_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tc_request(tc_request), .tc_grant(tc_grant),
        .tc_address(tc_address), .tc_read(tc_read), .tc_write(tc_write),
        .tc_chipselect(tc_chipselect), .tc_byteenable(tc_byteenable),
        .tc_writebyteenable(tc_writebyteenable), .tc_lock(tc_lock),
        .tc_begintransfer(tc_begintransfer), .tc_data_in(tc_data_in),
        .tc_data_out(tc_data_out), .tc_data_oe(tc_data_oe), .tc_waitrequest(tc_waitrequest),
        .tc_resetrequest(tc_resetrequest), .tc_irq(tc_irq), .tc_reset_out(tc_reset_out),
        .sys_reset_req(sys_reset_req), .irq(irq));

    ebso_dev_model dev (.pclk(pclk), .presetn(presetn), .tc_request(tc_request),
        .tc_address(tc_address), .tc_read(tc_read), .tc_write(tc_write),
        .tc_byteenable(tc_byteenable), .tc_data_out(tc_data_out), .grant_delay(grant_delay),
        .wait_n(wait_n), .tc_grant(tc_grant), .tc_data_in(tc_data_in),
        .tc_waitrequest(tc_waitrequest));

    // free-running clock
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : summarize

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        check(nm, r, exp);
    endtask : rd_chk

    task automatic wait_idle();
        logic [31:0] r;
        logic e;
        for (int i = 0; i < 40; i++) begin
            apb(1'b0, ebso_pkg::REG_STATUS, 32'h0000_0000, r, e);
            if (r[ebso_pkg::ST_BUSY_BIT] === 1'b0) break;
        end
        check("busy", {31'h0, r[ebso_pkg::ST_BUSY_BIT]}, 32'h0000_0000);
    endtask : wait_idle

    // pin watch: select pairing, begin pulses, holding under stall
    always @(posedge pclk) begin
        if (presetn) begin
            check("cs", tc_chipselect, tc_read | tc_write);
            check("wbe", tc_writebyteenable, 32'h0000_0000);
            check("oe", tc_data_oe, tc_write);
            check("begin", tc_begintransfer & st_p, 32'h0000_0000);
            if (st_p && wt_p) check("held", {tc_read | tc_write, tc_address}, {1'b1, addr_p});
            if (tc_begintransfer) begin
                n_begin++;
                seen_lock = tc_lock;
                seen_be = tc_byteenable;
                seen_data = tc_data_out;
                seen_addr = tc_address;
            end
            st_p = tc_read | tc_write;
            wt_p = tc_waitrequest;
            addr_p = tc_address;
        end
    end

    task automatic t_regs();
        logic [31:0] r;
        logic e;
        rd_chk("byteen", ebso_pkg::REG_BYTEEN, 32'h0000_000F);
        rd_chk("addr", ebso_pkg::REG_ADDR, 32'h0000_0000);
        rd_chk("ctrl", ebso_pkg::REG_CTRL, 32'h0000_0000);
        apb(1'b0, 8'h1C, 32'h0000_0000, r, e);
        check("unmapped", {e, r[30:0]}, 32'h8000_0000);
    endtask : t_regs

    task automatic t_write_partial();
        int nb;
        nb = n_begin;
        wr(ebso_pkg::REG_ADDR, 32'h0000_0010);
        wr(ebso_pkg::REG_WDATA, 32'h1122_3344);
        wr(ebso_pkg::REG_BYTEEN, 32'h0000_0005);
        wr(ebso_pkg::REG_CMD, 32'h0000_0002);
        wait_idle();
        check("nbegin", n_begin - nb, 32'h0000_0001);
        check("wdata", seen_data, 32'h0022_0044);
        check("be", seen_be, 32'h0000_0005);
        check("addr", seen_addr, 32'h0000_0010);
    endtask : t_write_partial

    task automatic t_read_lanes();
        wait_n <= 4'd0;
        wr(ebso_pkg::REG_BYTEEN, 32'h0000_0003);
        wr(ebso_pkg::REG_CMD, 32'h0000_0001);
        wait_idle();
        check("rbe", seen_be, 32'h0000_0003);
        rd_chk("rdata", ebso_pkg::REG_RDATA, 32'h0000_A544);
    endtask : t_read_lanes

    task automatic t_lock();
        wr(ebso_pkg::REG_ADDR, 32'h0000_0020);
        wr(ebso_pkg::REG_WDATA, 32'hDEAD_BEEF);
        wr(ebso_pkg::REG_BYTEEN, 32'h0000_000F);
        wr(ebso_pkg::REG_CMD, 32'h0000_0006);
        wait_idle();
        check("lock1", seen_lock, 32'h0000_0001);
        check("reqheld", tc_request, 32'h0000_0001);
        wr(ebso_pkg::REG_CMD, 32'h0000_0001);
        wait_idle();
        check("lock2", seen_lock, 32'h0000_0000);
        rd_chk("lockrd", ebso_pkg::REG_RDATA, 32'hDEAD_BEEF);
        check("reqdrop", tc_request, 32'h0000_0000);
    endtask : t_lock

    task automatic t_side();
        tc_irq <= 1'b1;
        tc_resetrequest <= 1'b1;
        repeat (3) @(posedge pclk);
        check("irq", irq, 32'h0000_0001);
        check("sysrst", sys_reset_req, 32'h0000_0001);
        rd_chk("status", ebso_pkg::REG_STATUS, 32'h0000_000C);
        tc_irq <= 1'b0;
        tc_resetrequest <= 1'b0;
        wr(ebso_pkg::REG_CTRL, 32'h0000_0001);
        repeat (3) @(posedge pclk);
        check("rstout", tc_reset_out, 32'h0000_0001);
        check("irqoff", {irq, sys_reset_req}, 32'h0000_0000);
    endtask : t_side

    // main sequence
    initial begin
        {presetn, psel, penable, pwrite, tc_irq, tc_resetrequest, st_p, wt_p} = '0;
        {paddr, pwdata, addr_p} = '0;
        {errors, n_checks, n_begin} = '0;
        grant_delay = 4'd2;
        wait_n = 4'd2;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_write_partial();
        t_read_lanes();
        t_lock();
        t_side();
        summarize();
    end

    // watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge pclk);
        errors++;
        summarize();
    end
endmodule : tb_ebso_ctrl
`default_nettype wire
